// ### rtl/sdpci_pkg.sv
// Shared constants, pin bundles and command decode of the SDRAM pin interface.
// Assumes one system clock shared with the memory controller.
package sdpci_pkg;
    localparam int ROW_W = 13;
    localparam int COL_W = 9;
    localparam int BA_W = 2;
    localparam int DQ_W = 16;
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int OP_W = BA_W + ROW_W;
    localparam int AP_BIT = 10;
    localparam int BL_W = 10;
    localparam int BL_LSB = 0;
    localparam int FIFO_DEPTH = 16;
    // Small model array: bank, low row bits, low column bits
    localparam int ARR_ROW_BITS = 2;
    localparam int ARR_COL_BITS = 4;
    localparam int ARR_AW = BA_W + ARR_ROW_BITS + ARR_COL_BITS;
    localparam int ARR_WORDS = 1 << ARR_AW;
    localparam logic [OP_W-1:0] MODE_RESET = 15'h0000;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_LMR, CMD_DESEL
    } sdpci_cmd_e;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACTIVE, ST_READ, ST_WRITE, ST_PD_PRE, ST_PD_ACT, ST_SELF
    } sdpci_state_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ROW_W-1:0] addr;
        logic [LANES-1:0] mask;
        logic [DQ_W-1:0] dq;
    } sdpci_pins_s;

    typedef struct packed {
        logic [ARR_AW-1:0] addr;
        logic [DQ_W-1:0] data;
        logic [LANES-1:0] mask;
    } sdpci_wr_s;

    function automatic sdpci_cmd_e sdpci_decode(input sdpci_pins_s p);
        if (p.cs_n) begin
            return CMD_DESEL;
        end
        case ({p.ras_n, p.cas_n, p.we_n})
            3'h3: return CMD_ACT;
            3'h5: return CMD_RD;
            3'h4: return CMD_WR;
            3'h2: return CMD_PRE;
            3'h1: return CMD_REF;
            3'h0: return CMD_LMR;
            default: return CMD_NOP;
        endcase
    endfunction

    function automatic logic [BL_W-1:0] sdpci_burst_len(input logic [2:0] f);
        case (f)
            3'h0: return 10'h001;
            3'h1: return 10'h002;
            3'h2: return 10'h004;
            3'h3: return 10'h008;
            3'h7: return 10'h200;
            default: return 10'h001;
        endcase
    endfunction
endpackage

// ### rtl/sdpci_top.sv
// SDRAM device-side pin interface: command decode, banks, bursts, masks.
// Assumes the controller runs on clk; only the wake path of the clock gate is synchronised.
// Function
// - All inputs registered on rising clock edge
// - Each edge advances burst column and output
// - Clock gate high runs clock, low stops
// - Gate low: power-down, self refresh, suspend
// - Clock gate synchronised asynchronously while powered down
// - Input buffers off in power-down, self refresh
// - Commands ignored while chip select high
// - Bursts and masks continue with chip select high
// - Command from select and three strobes
// - Masked write lanes leave array unchanged
// - Masked read lanes float two clocks later
// - Lower mask bits 0-7, upper 8-15
// - Bank select picks the addressed bank
// - Mode load takes bank and address op-code
// - Active registers thirteen-bit row address
// - Nine-bit column from address lines 0-8
// - Line 10 selects auto precharge after burst
// - Precharge line 10 high closes all banks

module sdpci_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem[rp_reg];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Pointer wrap relies on a power-of-two depth
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
endmodule

module sdpci_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdpci_pkg::BA_W-1:0] bank_select,
    input wire logic [sdpci_pkg::ROW_W-1:0] address_bus,
    // Data pins
    input wire logic lower_byte_mask,
    input wire logic upper_byte_mask,
    input wire logic [sdpci_pkg::DQ_W-1:0] data_lines_in,
    output logic [sdpci_pkg::DQ_W-1:0] data_lines_out,
    output logic [sdpci_pkg::LANES-1:0] data_lines_oe_n,
    // Power status
    output logic input_buffers_off,
    output logic self_refresh_active
);
    sdpci_pkg::sdpci_pins_s pins_q, pins_next;
    sdpci_pkg::sdpci_cmd_e cmd;
    sdpci_pkg::sdpci_state_e state_reg, state_next;
    sdpci_pkg::sdpci_wr_s push_data, pop_data;
    logic cke_q, cke_s1, cke_s2;
    logic [sdpci_pkg::LANES-1:0] dqm_d1_reg;
    logic [3:0] open_reg, open_next;
    logic [sdpci_pkg::ROW_W-1:0] row_reg [4];
    logic [sdpci_pkg::ROW_W-1:0] row_next [4];
    logic [sdpci_pkg::OP_W-1:0] mode_reg, mode_next;
    logic [sdpci_pkg::BA_W-1:0] bank_reg, bank_next;
    logic [sdpci_pkg::ARR_ROW_BITS-1:0] arow_reg, arow_next;
    logic [sdpci_pkg::COL_W-1:0] col_reg, col_next, col_step, bl_mask;
    logic [sdpci_pkg::BL_W-1:0] remain_reg, remain_next, bl;
    logic ap_reg, ap_next, drive_reg, drive_next;
    logic [sdpci_pkg::DQ_W-1:0] dout_reg, dout_next;
    logic [sdpci_pkg::LANES-1:0] oe_n_reg, oe_n_next;
    logic bufs_off_reg, bufs_off_next, self_reg, self_next;
    logic push_valid, push_ready, pop_valid;
    logic [sdpci_pkg::ARR_AW-1:0] arr_addr;
    logic [sdpci_pkg::DQ_W-1:0] mem [sdpci_pkg::ARR_WORDS];

    assign data_lines_out = dout_reg;
    assign data_lines_oe_n = oe_n_reg;
    assign input_buffers_off = bufs_off_reg;
    assign self_refresh_active = self_reg;

    // Pin stage freezes while the input buffers are off
    always_comb begin
        pins_next = pins_q;
        if (!bufs_off_reg) begin
            pins_next = '{cs_n, ras_n, cas_n, we_n, bank_select, address_bus,
                          {upper_byte_mask, lower_byte_mask}, data_lines_in};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_q <= '1;
            // Clock assumed running at release, so no false power-down
            cke_q <= 1'b1;
            cke_s1 <= 1'b1;
            cke_s2 <= 1'b1;
            dqm_d1_reg <= '1;
        end else begin
            pins_q <= pins_next;
            cke_q <= cke;
            cke_s1 <= cke;
            cke_s2 <= cke_s1;
            dqm_d1_reg <= pins_q.mask;
        end
    end

    always_comb begin
        cmd = sdpci_pkg::sdpci_decode(pins_q);
        bl = sdpci_pkg::sdpci_burst_len(mode_reg[sdpci_pkg::BL_LSB +: 3]);
        bl_mask = sdpci_pkg::COL_W'(bl - 1'b1);
        // Sequential wrap inside the burst block
        col_step = (col_reg & ~bl_mask) | ((col_reg + 1'b1) & bl_mask);
        arr_addr = {bank_reg, arow_reg, col_reg[sdpci_pkg::ARR_COL_BITS-1:0]};
        state_next = state_reg;
        open_next = open_reg;
        row_next = row_reg;
        mode_next = mode_reg;
        bank_next = bank_reg;
        arow_next = arow_reg;
        col_next = col_reg;
        remain_next = remain_reg;
        ap_next = ap_reg;
        dout_next = dout_reg;
        drive_next = drive_reg;
        push_valid = 1'b0;
        push_data = '{arr_addr, pins_q.dq, pins_q.mask};
        case (state_reg)
            sdpci_pkg::ST_PD_PRE, sdpci_pkg::ST_PD_ACT, sdpci_pkg::ST_SELF: begin
                drive_next = 1'b0;
                if (cke_s2) begin
                    state_next = sdpci_pkg::ST_IDLE;
                end
            end
            sdpci_pkg::ST_IDLE, sdpci_pkg::ST_ACTIVE, sdpci_pkg::ST_READ,
            sdpci_pkg::ST_WRITE: begin
                if (!cke_q) begin
                    // Suspend: bursts hold column and output
                    if (state_reg == sdpci_pkg::ST_IDLE && cmd == sdpci_pkg::CMD_REF) begin
                        state_next = sdpci_pkg::ST_SELF;
                    end else if (state_reg == sdpci_pkg::ST_IDLE) begin
                        state_next = sdpci_pkg::ST_PD_PRE;
                    end else if (state_reg == sdpci_pkg::ST_ACTIVE) begin
                        state_next = sdpci_pkg::ST_PD_ACT;
                    end
                end else begin
                    drive_next = 1'b0;
                    if (state_reg == sdpci_pkg::ST_READ ||
                        (state_reg == sdpci_pkg::ST_WRITE && push_ready)) begin
                        if (state_reg == sdpci_pkg::ST_READ) begin
                            dout_next = mem[arr_addr];
                            drive_next = 1'b1;
                        end else begin
                            push_valid = 1'b1;
                        end
                        col_next = col_step;
                        remain_next = remain_reg - 1'b1;
                        if (remain_reg == sdpci_pkg::BL_W'(1)) begin
                            state_next = sdpci_pkg::ST_IDLE;
                            if (ap_reg) begin
                                open_next[bank_reg] = 1'b0;
                            end
                        end
                    end
                    case (cmd)
                        sdpci_pkg::CMD_ACT: begin
                            open_next[pins_q.ba] = 1'b1;
                            row_next[pins_q.ba] = pins_q.addr;
                        end
                        sdpci_pkg::CMD_RD, sdpci_pkg::CMD_WR: begin
                            if (open_reg[pins_q.ba]) begin
                                bank_next = pins_q.ba;
                                arow_next = row_reg[pins_q.ba][sdpci_pkg::ARR_ROW_BITS-1:0];
                                col_next = pins_q.addr[sdpci_pkg::COL_W-1:0];
                                ap_next = pins_q.addr[sdpci_pkg::AP_BIT];
                                remain_next = bl;
                                state_next = (cmd == sdpci_pkg::CMD_RD) ?
                                    sdpci_pkg::ST_READ : sdpci_pkg::ST_WRITE;
                                if (cmd == sdpci_pkg::CMD_WR) begin
                                    // First word rides with the command
                                    col_next = (pins_q.addr[sdpci_pkg::COL_W-1:0] & ~bl_mask) |
                                        ((pins_q.addr[sdpci_pkg::COL_W-1:0] + 1'b1) & bl_mask);
                                    remain_next = bl - 1'b1;
                                    push_valid = 1'b1;
                                    push_data = '{{pins_q.ba,
                                        row_reg[pins_q.ba][sdpci_pkg::ARR_ROW_BITS-1:0],
                                        pins_q.addr[sdpci_pkg::ARR_COL_BITS-1:0]},
                                        pins_q.dq, pins_q.mask};
                                    if (bl == sdpci_pkg::BL_W'(1)) begin
                                        state_next = sdpci_pkg::ST_IDLE;
                                        if (pins_q.addr[sdpci_pkg::AP_BIT]) begin
                                            open_next[pins_q.ba] = 1'b0;
                                        end
                                    end
                                end
                            end
                        end
                        sdpci_pkg::CMD_PRE: begin
                            if (pins_q.addr[sdpci_pkg::AP_BIT]) begin
                                open_next = '0;
                            end else begin
                                open_next[pins_q.ba] = 1'b0;
                            end
                        end
                        sdpci_pkg::CMD_LMR: begin
                            mode_next = {pins_q.ba, pins_q.addr};
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: state_next = sdpci_pkg::ST_IDLE;
        endcase
        if (state_next == sdpci_pkg::ST_IDLE && |open_next) begin
            state_next = sdpci_pkg::ST_ACTIVE;
        end
        // Mask sampled two edges ago reaches the buffers now
        oe_n_next = drive_next ? dqm_d1_reg : '1;
        bufs_off_next = state_next == sdpci_pkg::ST_PD_PRE ||
            state_next == sdpci_pkg::ST_PD_ACT || state_next == sdpci_pkg::ST_SELF;
        self_next = state_next == sdpci_pkg::ST_SELF;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= sdpci_pkg::ST_IDLE;
            open_reg <= '0;
            row_reg <= '{default: '0};
            mode_reg <= sdpci_pkg::MODE_RESET;
            bank_reg <= '0;
            arow_reg <= '0;
            col_reg <= '0;
            remain_reg <= '0;
            ap_reg <= 1'b0;
            dout_reg <= '0;
            drive_reg <= 1'b0;
            oe_n_reg <= '1;
            bufs_off_reg <= 1'b0;
            self_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            open_reg <= open_next;
            row_reg <= row_next;
            mode_reg <= mode_next;
            bank_reg <= bank_next;
            arow_reg <= arow_next;
            col_reg <= col_next;
            remain_reg <= remain_next;
            ap_reg <= ap_next;
            dout_reg <= dout_next;
            drive_reg <= drive_next;
            oe_n_reg <= oe_n_next;
            bufs_off_reg <= bufs_off_next;
            self_reg <= self_next;
        end
    end

    // Write data queue drains only while the clock acts
    sdpci_fifo #(.WIDTH($bits(sdpci_pkg::sdpci_wr_s)), .DEPTH(sdpci_pkg::FIFO_DEPTH)) u_wq (
        .clk(clk),
        .rst(rst),
        .in_data(push_data),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(pop_data),
        .out_valid(pop_valid),
        .out_ready(cke_q)
    );

    // Reads may see stale data for words still queued; write recovery covers it
    // One process owns the array; lanes are enabled one by one
    always_ff @(posedge clk) begin
        for (int g = 0; g < sdpci_pkg::LANES; g++) begin
            if (pop_valid && cke_q && !pop_data.mask[g]) begin
                mem[pop_data.addr][g*sdpci_pkg::LANE_W +: sdpci_pkg::LANE_W] <=
                    pop_data.data[g*sdpci_pkg::LANE_W +: sdpci_pkg::LANE_W];
            end
        end
    end

    a_mask_read_hiz: assert property (@(posedge clk) disable iff (rst)
        (!bufs_off_reg && pins_q.mask[0]) |-> ##2 oe_n_reg[0])
        else $error("masked read lane still driven");
    a_cs_masks_cmd: assert property (@(posedge clk) disable iff (rst)
        (pins_q.cs_n && cke_q && state_reg == sdpci_pkg::ST_IDLE) |=>
        state_reg == sdpci_pkg::ST_IDLE && mode_reg == $past(mode_reg))
        else $error("deselected command took effect");
    a_precharge_all: assert property (@(posedge clk) disable iff (rst)
        (cke_q && cmd == sdpci_pkg::CMD_PRE && pins_q.addr[sdpci_pkg::AP_BIT] &&
        state_reg inside {sdpci_pkg::ST_IDLE, sdpci_pkg::ST_ACTIVE}) |=> open_reg == '0)
        else $error("precharge all left a bank open");
    a_active_opens: assert property (@(posedge clk) disable iff (rst)
        (cke_q && cmd == sdpci_pkg::CMD_ACT && state_reg == sdpci_pkg::ST_IDLE) |=>
        open_reg[$past(pins_q.ba)] && row_reg[$past(pins_q.ba)] == $past(pins_q.addr))
        else $error("active did not open row");
    a_mode_load: assert property (@(posedge clk) disable iff (rst)
        (cke_q && cmd == sdpci_pkg::CMD_LMR && state_reg == sdpci_pkg::ST_IDLE) |=>
        mode_reg == $past({pins_q.ba, pins_q.addr}))
        else $error("mode op-code not loaded");
    a_burst_count: assert property (@(posedge clk) disable iff (rst)
        (state_reg == sdpci_pkg::ST_READ && cke_q && cmd == sdpci_pkg::CMD_DESEL) |=>
        remain_reg == $past(remain_reg) - 1'b1 && drive_reg)
        else $error("burst did not advance");
    a_suspend_hold: assert property (@(posedge clk) disable iff (rst)
        (state_reg == sdpci_pkg::ST_READ && !cke_q) |=>
        $stable(col_reg) && $stable(dout_reg) && state_reg == sdpci_pkg::ST_READ)
        else $error("suspended burst moved");
    a_pd_buffers: assert property (@(posedge clk) disable iff (rst)
        (state_reg == sdpci_pkg::ST_IDLE && !cke_q && cmd != sdpci_pkg::CMD_REF) |=>
        bufs_off_reg && state_reg == sdpci_pkg::ST_PD_PRE ##1 $stable(pins_q))
        else $error("buffers live in power-down");
endmodule

// ### test/sdpci_host.sv
// Memory controller model: drives command, address, mask, data and clock gate pins.
// Assumes calls come from one bench process; pins change only at rising edges.
module sdpci_host (
    // Clock
    input wire logic clk,
    // Pins toward the memory
    output sdpci_pkg::sdpci_pins_s pins,
    output logic cke
);
    timeunit 1ns;
    timeprecision 1ps;

    // Select plus three strobes, customary code table
    function automatic logic [3:0] code(input sdpci_pkg::sdpci_cmd_e c);
        case (c)
            sdpci_pkg::CMD_ACT: return 4'h3;
            sdpci_pkg::CMD_RD: return 4'h5;
            sdpci_pkg::CMD_WR: return 4'h4;
            sdpci_pkg::CMD_PRE: return 4'h2;
            sdpci_pkg::CMD_REF: return 4'h1;
            sdpci_pkg::CMD_LMR: return 4'h0;
            sdpci_pkg::CMD_NOP: return 4'h7;
            default: return 4'hf;
        endcase
    endfunction

    initial begin
        pins = '1;
        cke = 1'b1;
    end

    // One command per edge; desel keeps the strobes but lifts chip select
    task automatic go(input sdpci_pkg::sdpci_cmd_e c, input logic [1:0] b,
            input logic [12:0] a, input logic [1:0] m, input logic [15:0] d,
            input logic k, input logic desel);
        @(posedge clk);
        pins <= {code(c) | {desel, 3'h0}, b, a, m, d};
        cke <= k;
    endtask

    // Idle lines flip so a stale value never looks valid
    task automatic rel(input logic [1:0] m, input logic [15:0] d, input logic k);
        go(sdpci_pkg::CMD_DESEL, ~pins.ba, ~pins.addr, m, d, k, 1'b0);
    endtask
endmodule

// ### test/test_sdram_pin_command_interface.sv
// Self-checking bench: controller model drives the pins, a behavioural
// memory predicts every read word and lane enable.
// Assumes the sixteen-bit part with read latency two and mode reset to single beats.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_sdram_pin_command_interface;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    sdpci_pkg::sdpci_pins_s pins;
    logic cke;
    logic [15:0] data_lines_out;
    logic [1:0] data_lines_oe_n;
    logic input_buffers_off;
    logic self_refresh_active;
    int num_errors = 0;
    int n_tests = 0;
    logic [15:0] mem [int];
    logic [12:0] row_of [4];
    bit open_b [4];
    int i, b, c;
    logic [15:0] d0, d1;

    initial begin
        forever #50 clk = ~clk;
    end

    sdpci_host u_host (.clk(clk), .pins(pins), .cke(cke));
    sdpci_top uut (.clk(clk), .rst(rst), .cke(cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
        .cas_n(pins.cas_n), .we_n(pins.we_n), .bank_select(pins.ba),
        .address_bus(pins.addr), .lower_byte_mask(pins.mask[0]),
        .upper_byte_mask(pins.mask[1]), .data_lines_in(pins.dq),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
        .input_buffers_off(input_buffers_off), .self_refresh_active(self_refresh_active));

    function automatic logic [15:0] lanes(input logic [1:0] m);
        return {{8{m[1]}}, {8{m[0]}}};
    endfunction

    // Small array alias: bank, low row bits, low column bits
    function automatic int idx(input int bk, input int col);
        return bk * 64 + 16 * int'(row_of[bk][1:0]) + (col & 15);
    endfunction

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) u_host.rel(2'h0, 16'($urandom), 1'b1);
    endtask

    task automatic put(input int k, input logic [15:0] w, input logic [1:0] m);
        mem[k] = ((mem.exists(k) ? mem[k] : 16'hxxxx) & lanes(m)) | (w & ~lanes(m));
    endtask

    task automatic wr(input int bk, col, input logic [15:0] w0, w1, input logic [1:0] m0, m1);
        u_host.go(sdpci_pkg::CMD_WR, 2'(bk), 13'(col), m0, w0, 1'b1, 1'b0);
        u_host.rel(m1, w1, 1'b1);
        if (open_b[bk]) begin
            put(idx(bk, col), w0, m0);
            put(idx(bk, col ^ 1), w1, m1);
        end
        idle(3);
    endtask

    task automatic rd(input int bk, col, input bit ap, input logic [1:0] m0, m1);
        bit live;
        logic [15:0] e0, e1;
        live = open_b[bk];
        e0 = live ? mem[idx(bk, col)] : 16'h0000;
        e1 = live ? mem[idx(bk, col ^ 1)] : 16'h0000;
        u_host.go(sdpci_pkg::CMD_RD, 2'(bk), 13'(col) | {2'h0, ap, 10'h000}, m0,
            16'($urandom), 1'b1, 1'b0);
        u_host.rel(m1, 16'($urandom), 1'b1);
        u_host.rel(2'h0, 16'($urandom), 1'b1);
        @(posedge clk);
        @(negedge clk);
        `CHK(data_lines_oe_n, live ? m0 : 2'h3)
        if (live) `CHK(data_lines_out & ~lanes(m0), e0 & ~lanes(m0))
        @(negedge clk);
        `CHK(data_lines_oe_n, live ? m1 : 2'h3)
        if (live) `CHK(data_lines_out & ~lanes(m1), e1 & ~lanes(m1))
        @(negedge clk);
        `CHK(data_lines_oe_n, 2'h3)
        if (ap) open_b[bk] = 1'b0;
    endtask

    // Exit goes through a synchroniser, so allow a few edges
    task automatic wake();
        for (i = 0; i < 8 && (input_buffers_off | self_refresh_active) !== 1'b0; i++) begin
            @(negedge clk);
        end
        `CHK(input_buffers_off | self_refresh_active, 1'b0)
        if ((input_buffers_off | self_refresh_active) !== 1'b0) print_verdict();
        idle(2);
    endtask

    initial begin
        void'($urandom(91346));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(data_lines_oe_n, 2'h3)
        `CHK({input_buffers_off, self_refresh_active}, 2'h0)
        $display("test reset done");
        u_host.go(sdpci_pkg::CMD_LMR, 2'h0, 13'h0001, 2'h0, 16'h0000, 1'b1, 1'b0);
        idle(2);
        for (b = 0; b < 4; b++) begin
            row_of[b] = 13'($urandom);
            open_b[b] = 1'b1;
            u_host.go(sdpci_pkg::CMD_ACT, 2'(b), row_of[b], 2'h0, 16'h0000, 1'b1, 1'b0);
        end
        idle(2);
        for (i = 0; i < 8; i++) begin
            b = $urandom % 4;
            c = $urandom % 512;
            d0 = 16'($urandom);
            d1 = 16'($urandom);
            wr(b, c, d0, d1, 2'h0, 2'h0);
            wr(b, c, ~d0, ~d1, 2'(i), 2'(i + 1));
            rd(b, c, 1'b0, 2'(i + 2), 2'(i >> 1));
        end
        $display("test random done");
        wr(0, 5, 16'h1234, 16'h5678, 2'h0, 2'h0);
        u_host.go(sdpci_pkg::CMD_WR, 2'h0, 13'h0005, 2'h0, 16'hdead, 1'b1, 1'b1);
        u_host.rel(2'h0, 16'hbeef, 1'b1);
        idle(3);
        rd(0, 5, 1'b0, 2'h0, 2'h0);
        $display("test deselect done");
        wr(2, 6, 16'h0f0f, 16'hf0f0, 2'h0, 2'h0);
        u_host.go(sdpci_pkg::CMD_PRE, 2'h1, 13'h0000, 2'h0, 16'h0000, 1'b1, 1'b0);
        open_b[1] = 1'b0;
        idle(2);
        rd(1, 6, 1'b0, 2'h0, 2'h0);
        rd(2, 6, 1'b1, 2'h0, 2'h0);
        rd(2, 6, 1'b0, 2'h0, 2'h0);
        u_host.go(sdpci_pkg::CMD_PRE, 2'h1, 13'h0400, 2'h0, 16'h0000, 1'b1, 1'b0);
        open_b = '{default: 1'b0};
        idle(2);
        rd(0, 5, 1'b0, 2'h0, 2'h0);
        u_host.go(sdpci_pkg::CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000, 1'b1, 1'b0);
        idle(3);
        rd(3, 0, 1'b0, 2'h0, 2'h0);
        $display("test precharge done");
        u_host.rel(2'h0, 16'h0000, 1'b0);
        u_host.rel(2'h0, 16'h0000, 1'b0);
        u_host.go(sdpci_pkg::CMD_ACT, 2'h0, 13'h0000, 2'h0, 16'h0000, 1'b0, 1'b0);
        @(negedge clk);
        `CHK({input_buffers_off, self_refresh_active}, 2'h2)
        u_host.rel(2'h0, 16'h0000, 1'b1);
        wake();
        rd(0, 5, 1'b0, 2'h0, 2'h0);
        u_host.go(sdpci_pkg::CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0000, 1'b0, 1'b0);
        u_host.rel(2'h0, 16'h0000, 1'b0);
        u_host.rel(2'h0, 16'h0000, 1'b0);
        @(negedge clk);
        `CHK({input_buffers_off, self_refresh_active}, 2'h3)
        u_host.rel(2'h0, 16'h0000, 1'b1);
        wake();
        rd(0, 5, 1'b0, 2'h0, 2'h0);
        $display("test power done");
        print_verdict();
    end
endmodule
